// [core/hcu_top.v]
// hardware cursor: host register port, cursor storage and display overlay
// Function
// RULE1: enable bit 0 takes effect only at next vertical sync.
// RULE2: bit 1 selects one 64x64 cursor or four 32x32, applied at vsync.
// RULE3: bits 3-2 pick shown small cursor, applied at vsync.
// RULE4: bit 5 sets origin at display-enable corner or blanking corner.
// RULE5: index bits 17-16 choose a 16-bit word of a row.
// RULE6: bits 23-18 pick row; in small mode 23-22 pick cursor.
// RULE7: storage is AND plane then XOR plane, bit 24 chooses.
// RULE8: every data port access advances the word pointer.
// RULE9: writes gather in 64-bit buffer, committed on last word.
// RULE10: host starts at word 0 and writes all 64 bits of a row.
// RULE11: reads return any addressed 16-bit word directly.
// RULE12: host sets an even word before 32-bit data accesses.
// RULE13: colours are 24-bit blue, green, red; top byte reads zero.
// RULE14: colour writes take effect at once.
// RULE15: X position is 11-bit magnitude with sign bit 15.
// RULE16: Y position is magnitude bits 26-16 with sign bit 31.
// RULE17: reserved bits between magnitude and sign are ignored.
// RULE18: registers accept 16-bit halves or 32-bit access.
// RULE19: data register is a 32-bit window addressed by the pointer.
// RULE20: AND/XOR bits select colour 0, colour 1, pixel or inverted pixel.
`timescale 1ns/1ps
`include "hcu_regs.vh"
module hcu_top (
	input  wire        clk,
	input  wire        rst,
	input  wire [15:0] ioAddr,
	input  wire [3:0]  ioByteEn,
	input  wire        ioWr,
	input  wire        ioRd,
	input  wire [31:0] ioWrData,
	output reg  [31:0] ioRdData,
	input  wire        vsyncIn,
	input  wire        blankIn,
	input  wire        dispEnIn,
	input  wire [23:0] pixelIn,
	output reg  [23:0] pixelOut
);
	// synchronised display timing inputs
	reg [2:0] vs_q;
	reg [1:0] bl_q;
	reg [1:0] de_q;
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			vs_q <= 3'h0;
			bl_q <= 2'h0;
			de_q <= 2'h0;
		end
		else
		begin
			vs_q <= {vs_q[1:0], vsyncIn};
			bl_q <= {bl_q[0], blankIn};
			de_q <= {de_q[0], dispEnIn};
		end
	end
	wire vsRise = vs_q[1] & ~vs_q[2];
	wire activeArea = bl_q[1];
	wire visible = de_q[1];
	// cursor window follows the selected corner: display enable or blanking
	wire inArea = (ctrl_q[`HCU_CTL_ORIGIN] ? visible : activeArea); // RULE4

	function [31:0] merge;
		input [31:0] oldV;
		input [31:0] newV;
		input [3:0]  be;
		integer i;
		begin
			merge = oldV;
			for (i = 0; i < 4; i = i + 1)
				if (be[i])
					merge[i*8 +: 8] = newV[i*8 +: 8];
		end
	endfunction

	wire selCtrl = (ioAddr == `HCU_OFS_CTRL);
	wire selC0   = (ioAddr == `HCU_OFS_COLOR0);
	wire selC1   = (ioAddr == `HCU_OFS_COLOR1);
	wire selPos  = (ioAddr == `HCU_OFS_POS);
	wire selRam  = (ioAddr == `HCU_OFS_RAMPORT);

	reg  [31:0] ctrl_q;
	reg  [31:0] color0_q;
	reg  [31:0] color1_q;
	reg  [31:0] pos_q;
	reg  [63:0] hold_q;
	reg  [3:0]  shown_q;
	wire [1:0]  word = ctrl_q[`HCU_CTL_WORD_LO +: 2]; // RULE5
	wire [6:0]  ptrRow = {ctrl_q[`HCU_CTL_PLANE], ctrl_q[`HCU_CTL_ROW_LO +: 6]}; // RULE6 RULE7
	wire        wide = ioByteEn[3] | ioByteEn[2];
	wire        lowHalf = ioByteEn[0] | ioByteEn[1];
	wire        dword = wide & lowHalf;
	wire        ramAcc = selRam & (ioWr | ioRd);

	// pointer advance: one word per 16-bit access, two per 32-bit
	wire [1:0] step = dword ? 2'h2 : 2'h1;
	wire [8:0] ptrNext = ctrl_q[24:16] + {7'h0, step}; // RULE8

	wire commit = selRam & ioWr & ((dword & (word == 2'h2)) | (~dword & (word == 2'h3))); // RULE9
	// holding buffer: each 16-bit slot takes the half that the access aims at
	wire [1:0]  wordUp = word + 2'h1;
	wire [15:0] halfIn = (ioByteEn[1:0] != 2'h0) ? ioWrData[15:0] : ioWrData[31:16];
	wire [63:0] holdNext;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : gHold
			wire lowHit  = ({30'h0, word} == g);
			wire highHit = dword & ({30'h0, wordUp} == g);
			assign holdNext[g*16 +: 16] = lowHit ? (dword ? ioWrData[15:0] : halfIn)
				: highHit ? ioWrData[31:16]
				: hold_q[g*16 +: 16]; // RULE9
		end
	endgenerate

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_q   <= `HCU_RESET_CTRL;
			color0_q <= `HCU_RESET_WORD;
			color1_q <= `HCU_RESET_WORD;
			pos_q    <= `HCU_RESET_WORD;
			hold_q   <= 64'h0;
			shown_q  <= 4'h0;
		end
		else
		begin
			if (ioWr & selCtrl)
				ctrl_q <= merge(ctrl_q, ioWrData, ioByteEn) & `HCU_CTL_MASK; // RULE18
			else if (ramAcc)
				ctrl_q[24:16] <= ptrNext; // RULE8
			if (ioWr & selC0)
				color0_q <= merge(color0_q, ioWrData, ioByteEn) & `HCU_COLOR_MASK; // RULE13 RULE14
			if (ioWr & selC1)
				color1_q <= merge(color1_q, ioWrData, ioByteEn) & `HCU_COLOR_MASK; // RULE13 RULE14
			if (ioWr & selPos)
				pos_q <= merge(pos_q, ioWrData, ioByteEn) & `HCU_POS_MASK; // RULE17
			if (selRam & ioWr)
				hold_q <= holdNext; // RULE9
			if (vsRise)
				shown_q <= ctrl_q[3:0]; // RULE1 RULE2 RULE3
		end
	end

	// cursor storage
	reg  [6:0]  dispAndRow;
	wire [63:0] ramA;
	wire [63:0] ramB;
	hcu_ram #(.ROWS(128)) uRam (
		.clk    (clk),
		.wrEn   (commit),
		.wrRow  (ptrRow),
		.wrData (holdNext),
		.rdRowA (dispAndRow),
		.rdRowB ({1'b1, dispAndRow[5:0]}),
		.rdDataA(ramA),
		.rdDataB(ramB)
	);

	// mirror copy for host reads, so a read never disturbs the display fetch
	wire [63:0] hostRow;
	hcu_ram #(.ROWS(128)) uRamHost (
		.clk    (clk),
		.wrEn   (commit),
		.wrRow  (ptrRow),
		.wrData (holdNext),
		.rdRowA (ptrRow),
		.rdRowB (ptrRow),
		.rdDataA(hostRow),
		.rdDataB()
	);
	// addressed word straight from the row, no buffering
	wire [15:0] ramWord16 = hostRow[{word, 4'h0} +: 16]; // RULE11
	wire [31:0] ramWord32 = {hostRow[{wordUp, 4'h0} +: 16], ramWord16}; // RULE19

	// display position counters
	reg [11:0] hCnt_q;
	reg [11:0] vCnt_q;
	reg        prevAct_q;
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			hCnt_q <= 12'h0;
			vCnt_q <= 12'h0;
			prevAct_q <= 1'b0;
		end
		else
		begin
			prevAct_q <= inArea;
			if (vsRise)
			begin
				hCnt_q <= 12'h0;
				vCnt_q <= 12'h0;
			end
			else if (inArea) // RULE4
				hCnt_q <= hCnt_q + 12'h1;
			else if (prevAct_q)
			begin
				hCnt_q <= 12'h0;
				vCnt_q <= vCnt_q + 12'h1;
			end
		end
	end

	// signed cursor origin and pixel offset within the cursor
	wire signed [12:0] xPos = pos_q[15] ? -$signed({2'b0, pos_q[10:0]})
		: $signed({2'b0, pos_q[10:0]}); // RULE15
	wire signed [12:0] yPos = pos_q[31] ? -$signed({2'b0, pos_q[26:16]})
		: $signed({2'b0, pos_q[26:16]}); // RULE16
	wire signed [13:0] dx = $signed({2'b0, hCnt_q}) - xPos;
	wire signed [13:0] dy = $signed({2'b0, vCnt_q}) - yPos;
	wire [6:0] span = shown_q[`HCU_CTL_SIZE64] ? 7'd64 : 7'd32; // RULE2
	// offset lies inside the cursor square
	function inSpan;
		input signed [13:0] d;
		input        [6:0]  s;
		begin
			inSpan = (d >= 14'sd0) && (d < $signed({7'h0, s}));
		end
	endfunction
	wire inX = inSpan(dx, span);
	wire inY = inSpan(dy, span);
	wire hit = shown_q[`HCU_CTL_EN] & inArea & inX & inY; // RULE1
	// a small cursor packs two 32-pixel lines into each 64-bit row
	always @*
	begin
		if (shown_q[`HCU_CTL_SIZE64])
			dispAndRow = {1'b0, dy[5:0]};
		else
			dispAndRow = {1'b0, shown_q[3:2], dy[4:1]}; // RULE3 RULE6
	end
	wire [5:0] bitIdx = shown_q[`HCU_CTL_SIZE64] ? dx[5:0] : {dy[0], dx[4:0]};
	wire andBit = ramA[6'd63 - bitIdx];
	wire xorBit = ramB[6'd63 - bitIdx];
	wire [23:0] mixOut;
	hcu_mix uMix (
		.hit      (hit),
		.andBit   (andBit),
		.xorBit   (xorBit),
		.colorZero(color0_q[23:0]),
		.colorOne (color1_q[23:0]),
		.pixelIn  (pixelIn),
		.pixelOut (mixOut)
	);

	// host read data for the addressed register; unmapped reads give zero
	reg [31:0] rdNext;
	always @*
	begin
		rdNext = 32'h0;
		case (1'b1)
		selCtrl: rdNext = ctrl_q;
		selC0:   rdNext = color0_q; // RULE13
		selC1:   rdNext = color1_q; // RULE13
		selPos:  rdNext = pos_q;
		selRam:  rdNext = dword ? ramWord32 : {2{ramWord16}}; // RULE11 RULE19
		default: rdNext = 32'h0;
		endcase
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pixelOut <= 24'h0;
			ioRdData <= 32'h0;
		end
		else
		begin
			pixelOut <= mixOut;
			if (ioRd)
				ioRdData <= rdNext;
		end
	end
endmodule

// [core/hcu_regs.vh]
// register offsets, field positions and reset values of the hardware cursor
`ifndef HCU_REGS_VH
`define HCU_REGS_VH
`define HCU_OFS_CTRL     16'ha3d0
`define HCU_OFS_COLOR0   16'ha7d0
`define HCU_OFS_COLOR1   16'habd0
`define HCU_OFS_POS      16'hafd0
`define HCU_OFS_RAMPORT  16'hb3d0
`define HCU_CTL_EN       0
`define HCU_CTL_SIZE64   1
`define HCU_CTL_SEL_LO   2
`define HCU_CTL_ORIGIN   5
`define HCU_CTL_WORD_LO  16
`define HCU_CTL_ROW_LO   18
`define HCU_CTL_PLANE    24
`define HCU_CTL_MASK     32'h01ff002f
`define HCU_COLOR_MASK   32'h00ffffff
`define HCU_POS_MASK     32'h87ff87ff
`define HCU_RESET_CTRL   32'h00000000
`define HCU_RESET_WORD   32'h00000000
`endif

// [core/hcu_ram.v]
// two-plane cursor storage: 128 rows of 64 bits, row write and two row read ports
`timescale 1ns/1ps
module hcu_ram #(
	parameter ROWS = 128
)(
	input  wire        clk,
	input  wire        wrEn,
	input  wire [6:0]  wrRow,
	input  wire [63:0] wrData,
	input  wire [6:0]  rdRowA,
	input  wire [6:0]  rdRowB,
	output wire [63:0] rdDataA,
	output wire [63:0] rdDataB
);
	reg [63:0] mem [0:ROWS-1];
	always @(posedge clk)
	begin
		if (wrEn)
			mem[wrRow] <= wrData;
	end
	assign rdDataA = mem[rdRowA];
	assign rdDataB = mem[rdRowB];
endmodule

// [core/hcu_mix.v]
// per-pixel two-plane cursor combine into a 24-bit colour
`timescale 1ns/1ps
module hcu_mix (
	input  wire        hit,
	input  wire        andBit,
	input  wire        xorBit,
	input  wire [23:0] colorZero,
	input  wire [23:0] colorOne,
	input  wire [23:0] pixelIn,
	output reg  [23:0] pixelOut
);
	always @*
	begin
		if (!hit)
			pixelOut = pixelIn;
		else
			case ({andBit, xorBit}) // RULE20
			2'b00:   pixelOut = colorZero;
			2'b01:   pixelOut = colorOne;
			2'b10:   pixelOut = pixelIn;
			default: pixelOut = ~pixelIn;
			endcase
	end
endmodule

// [dv/hcu_host.sv]
// host processor model driving the cursor register port
`timescale 1ns/1ps
module hcu_host (
	input  wire        clk,
	output reg  [15:0] ioAddr,
	output reg  [3:0]  ioByteEn,
	output reg         ioWr,
	output reg         ioRd,
	output reg  [31:0] ioWrData,
	input  wire [31:0] ioRdData
);
	initial
	begin
		{ioAddr, ioByteEn, ioWr, ioRd, ioWrData} = '0;
	end
	task wr(input [15:0] a, input [3:0] b, input [31:0] d);
	begin
		@(negedge clk);
		{ioAddr, ioByteEn, ioWrData, ioWr} = {a, b, d, 1'b1};
		@(negedge clk);
		{ioAddr, ioWrData, ioWr} = {~a, ~d, 1'b0};
	end
	endtask
	task rd(input [15:0] a, input [3:0] b, output [31:0] q);
	begin
		@(negedge clk);
		{ioAddr, ioByteEn, ioRd} = {a, b, 1'b1};
		@(negedge clk);
		q = ioRdData;
		{ioAddr, ioRd} = {~a, 1'b0};
	end
	endtask
	// whole row from word 0 as two doublewords
	task row(input p, input [5:0] r, input [63:0] d);
	begin
		wr(16'ha3d0, 4'hc, {7'h0, p, r, 2'h0, 16'h0});
		wr(16'hb3d0, 4'hf, d[31:0]);
		wr(16'hb3d0, 4'hf, d[63:32]);
	end
	endtask
endmodule

// [dv/hcu_top_asserts.sv]
// concurrent checks on the cursor register port
`timescale 1ns/1ps
module hcu_top_chk (
	input wire        clk,
	input wire        rst,
	input wire [15:0] ioAddr,
	input wire [3:0]  ioByteEn,
	input wire        ioWr,
	input wire        ioRd,
	input wire [31:0] ioWrData,
	input wire [31:0] ioRdData
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire mapped = ioAddr[9:0] == 10'h3d0 && ioAddr[15:10] >= 6'h28 && ioAddr[15:10] <= 6'h2c;
	unmapped_zero_a: assert property (ioRd && !mapped |=> ioRdData == 0)
		else $error("unmapped read not zero");
	color0_top_a: assert property (ioRd && ioAddr == 16'ha7d0 |=> ioRdData[31:24] == 0)
		else $error("colour 0 top byte set");
	color1_top_a: assert property (ioRd && ioAddr == 16'habd0 |=> ioRdData[31:24] == 0)
		else $error("colour 1 top byte set");
	pos_reserved_a: assert property (ioRd && ioAddr == 16'hafd0 |=> (ioRdData & 32'h78007800) == 0)
		else $error("position reserved bits set");
	ctrl_reserved_a: assert property (ioRd && ioAddr == 16'ha3d0 |=> (ioRdData & 32'hfe00ffd0) == 0)
		else $error("control reserved bits set");
	rdata_hold_a: assert property (!ioRd |=> $stable(ioRdData))
		else $error("read data moved without read");
	color_back_a: assert property (ioWr && ioAddr == 16'ha7d0 && ioByteEn == 4'hf ##1 !ioWr
		##1 ioRd && ioAddr == 16'ha7d0 |=> ioRdData == ($past(ioWrData, 3) & 32'h00ffffff))
		else $error("colour readback wrong");
	pos_back_a: assert property (ioWr && ioAddr == 16'hafd0 && ioByteEn == 4'hf ##1 !ioWr
		##1 ioRd && ioAddr == 16'hafd0 |=> ioRdData == ($past(ioWrData, 3) & 32'h87ff87ff))
		else $error("position readback wrong");
	cover property (ioWr && ioAddr == 16'hb3d0 && ioByteEn == 4'hf);
	cover property (ioWr && ioAddr == 16'hb3d0 && ioByteEn == 4'h3);
	cover property (ioRd && ioAddr == 16'hb3d0);
endmodule
bind hcu_top hcu_top_chk chk (.clk(clk), .rst(rst), .ioAddr(ioAddr), .ioByteEn(ioByteEn),
	.ioWr(ioWr), .ioRd(ioRd), .ioWrData(ioWrData), .ioRdData(ioRdData));

// [dv/tb.sv]
// self-checking bench for the hardware cursor
`timescale 1ns/1ps
module tb;
	logic        clk = 0;
	logic        rst = 1;
	logic        vsyncIn = 0;
	logic        blankIn = 1;
	logic        dispEnIn = 1;
	logic [23:0] pixelIn = 24'h5a3c96;
	wire  [23:0] pixelOut;
	wire  [15:0] ioAddr;
	wire  [3:0]  ioByteEn;
	wire         ioWr;
	wire         ioRd;
	wire  [31:0] ioWrData;
	wire  [31:0] ioRdData;
	logic [31:0] q;
	int          miscompares = 0;
	int          checksDone = 0;
	int          cycles = 0;
	always #5 clk = ~clk;
	hcu_top uut (.clk(clk), .rst(rst), .ioAddr(ioAddr), .ioByteEn(ioByteEn), .ioWr(ioWr),
		.ioRd(ioRd), .ioWrData(ioWrData), .ioRdData(ioRdData), .vsyncIn(vsyncIn),
		.blankIn(blankIn), .dispEnIn(dispEnIn), .pixelIn(pixelIn), .pixelOut(pixelOut));
	hcu_host host (.clk(clk), .ioAddr(ioAddr), .ioByteEn(ioByteEn), .ioWr(ioWr),
		.ioRd(ioRd), .ioWrData(ioWrData), .ioRdData(ioRdData));
	task chk(input [31:0] s, input [31:0] e);
	begin
		checksDone++;
		if (s !== e)
		begin
			miscompares++;
			$display("mismatch %0t %h %h", $time, s, e);
		end
	end
	endtask
	task summarize;
	begin
		if (miscompares == 0 && checksDone > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			summarize;
		end
	end
	task t_color;
	begin
		host.wr(16'ha7d0, 4'hf, 32'hff123456);
		host.rd(16'ha7d0, 4'hf, q);
		chk(q, 32'h00123456);
		host.wr(16'habd0, 4'h3, 32'h0000beef);
		host.wr(16'habd0, 4'hc, 32'hffab0000);
		host.rd(16'habd0, 4'hf, q);
		chk(q, 32'h00abbeef);
	end
	endtask
	task t_pos;
	begin
		host.wr(16'hafd0, 4'hf, 32'hffffffff);
		host.rd(16'hafd0, 4'hf, q);
		chk(q, 32'h87ff87ff);
		host.wr(16'hafd0, 4'h3, 32'h00008001);
		host.rd(16'hafd0, 4'hf, q);
		chk(q, 32'h87ff8001);
		host.wr(16'hb7d0, 4'hf, 32'hffffffff);
		host.rd(16'hb7d0, 4'hf, q);
		chk(q, 32'h0);
	end
	endtask
	task t_ram;
		int i;
	begin
		host.wr(16'ha3d0, 4'h3, 32'h3);
		host.wr(16'ha3d0, 4'hc, 32'h01fc0000);
		for (i = 0; i < 4; i++)
			host.wr(16'hb3d0, 4'h3, 32'h1111 * (i + 1));
		host.row(1'b0, 6'h3f, 64'h0);
		host.row(1'b0, 6'h05, 64'h0123456789abcdef);
		host.wr(16'ha3d0, 4'hc, 32'h00160000);
		host.rd(16'hb3d0, 4'hf, q);
		chk(q, 32'h01234567);
		host.wr(16'ha3d0, 4'hc, 32'h00150000);
		host.rd(16'hb3d0, 4'h3, q);
		chk(q[15:0], 32'h89ab);
		host.rd(16'ha3d0, 4'hf, q);
		chk(q, 32'h00160003);
		host.wr(16'ha3d0, 4'hc, 32'h01fc0000);
		host.rd(16'hb3d0, 4'hf, q);
		chk(q, 32'h22221111);
		chk(pixelOut, pixelIn);
	end
	endtask
	task t_disp;
	begin
		host.wr(16'ha7d0, 4'hf, 32'h00112233);
		host.wr(16'habd0, 4'hf, 32'h00445566);
		host.row(1'b0, 6'h00, 64'h0);
		host.row(1'b1, 6'h00, 64'h00000000ffffffff);
		host.wr(16'hafd0, 4'hf, 32'h0);
		host.wr(16'ha3d0, 4'h3, 32'h23);
		repeat (4) @(negedge clk);
		chk(pixelOut, pixelIn);
		vsyncIn = 1;
		repeat (6) @(negedge clk);
		chk(pixelOut, 24'h112233);
		repeat (38) @(negedge clk);
		chk(pixelOut, 24'h445566);
		repeat (30) @(negedge clk);
		chk(pixelOut, pixelIn);
		vsyncIn = 0;
		dispEnIn = 0;
		repeat (4) @(negedge clk);
		vsyncIn = 1;
		repeat (6) @(negedge clk);
		chk(pixelOut, pixelIn);
		vsyncIn = 0;
		dispEnIn = 1;
	end
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 0;
		t_color;
		t_pos;
		t_ram;
		t_disp;
		summarize;
	end
endmodule
